// >>> verilog/scs_spi_port.sv
// Clock-stop (SPI) engine of the buffered serial port, master or slave role.
// Assumes all pins are synchronous to clk_sys; pad logic resolves the enables.
`timescale 1ns/1ps
`include "scs_spi_map.svh"

// Summary of operation
// - Rate source is CPU clock over four when select is 1, else external pin.
// - Bit clock period is source period times one plus divide value, or two periods when divide is zero.
// - High phase: divide/2+1 periods if even, (divide+1)/2 if odd, one period if zero.
// - Low phase: divide/2 periods if even, (divide+1)/2 if odd, one period if zero.
// - Master drives transmit frame sync as slave select, inverted (active low) only when tx_sync_polarity is 1.
// - Slave XORs both frame-sync pins with their polarity bits into active-high selects before use.
// - Master drives bit clock and frame sync; receive clock and sync are inputs.
// - Slave sets all four direction settings to 0; master supplies everything.
// - Select goes active before a clock edge; transfer starts at clock edge.
// - Mode 10b: data changes after lead edge, sampled at following edge.
// - Mode 11b: data changes after trail edge, half a cycle earlier.
// - Master select lead and trail spacing: idle phase and period, swapped in 11b.
// - Slave data output goes high impedance once select is released.
module scs_spi_port #(
	parameter int WORD_BITS = 8,
	parameter int DIV_W     = 8
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	// Configuration
	input  wire logic                 role_master,
	input  wire logic [1:0]           clock_stop_mode,
	input  wire logic                 tx_clock_polarity,
	input  wire logic                 tx_sync_polarity,
	input  wire logic                 rx_sync_polarity,
	input  wire logic                 rate_source_select,
	input  wire logic [DIV_W-1:0]     clock_divide_value,
	// Direction status
	output logic                      tx_clock_direction,
	output logic                      rx_clock_direction,
	output logic                      tx_sync_direction,
	output logic                      rx_sync_direction,
	// Rate clock pin
	input  wire logic                 rate_clock_in,
	// Serial pins
	input  wire logic                 tx_bit_clock_in,
	output logic                      tx_bit_clock_out,
	output logic                      tx_bit_clock_oe,
	input  wire logic                 tx_frame_sync_in,
	output logic                      tx_frame_sync_out,
	output logic                      tx_frame_sync_oe,
	input  wire logic                 rx_frame_sync_in,
	input  wire logic                 serial_data_in,
	output logic                      serial_data_out,
	output logic                      serial_data_oe,
	// User side
	input  wire logic [WORD_BITS-1:0] tx_data,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output logic [WORD_BITS-1:0]      rx_data,
	output logic                      rx_valid,
	output logic                      busy
);

	localparam int CW    = $clog2(WORD_BITS + 1);
	localparam int LEN_W = DIV_W + 1;

	typedef struct packed {
		scs_pkg::scs_state_t  st;
		logic                 master;
		logic                 clk_lvl;
		logic                 clk_prev;
		logic                 sel;
		logic                 fs_pin;
		logic                 dout;
		logic                 doe;
		logic                 away;
		logic [LEN_W-1:0]     cnt;
		logic [CW-1:0]        cap_cnt;
		logic [WORD_BITS-1:0] txsh;
		logic [WORD_BITS-1:0] rxsh;
		logic [WORD_BITS-1:0] rx_word;
		logic                 rx_pulse;
	} scs_port_state_t;

	scs_port_state_t s_r;
	scs_port_state_t s_nxt;

	logic             src_tick;
	logic [LEN_W-1:0] hi_len;
	logic [LEN_W-1:0] lo_len;
	logic [LEN_W-1:0] idle_len;
	logic [LEN_W-1:0] away_len;
	logic [LEN_W-1:0] period_len;
	logic [LEN_W-1:0] lead_len;
	logic [LEN_W-1:0] trail_len;
	logic             stop_en;
	logic             early;
	logic             tx_sel_act;
	logic             rx_sel_act;
	logic             slv_lead;
	logic             slv_trail;
	logic             phase_end;
	logic             last_bit;
	logic             do_launch;
	logic             do_capture;

	////////////////////////////////////////////////////////////////////////
	// Rate generator
	scs_rate_if #(.DIV_W(DIV_W)) rate_bus ();

	assign rate_bus.divide  = clock_divide_value;
	assign rate_bus.src_sel = rate_source_select;
	assign rate_bus.ext_clk = rate_clock_in;
	assign src_tick         = rate_bus.src_tick;
	assign hi_len           = rate_bus.hi_len;
	assign lo_len           = rate_bus.lo_len;

	scs_rate_gen u_rate (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.rate    (rate_bus.gen)
	);

	////////////////////////////////////////////////////////////////////////
	// Derived settings
	assign stop_en    = clock_stop_mode[`SCS_STOP_EN_BIT];
	assign early      = (clock_stop_mode == `SCS_MODE_STOP_EARLY);
	assign period_len = hi_len + lo_len;
	// Idle-level phase: high phase when clock idles high
	assign idle_len   = tx_clock_polarity ? hi_len : lo_len;
	assign away_len   = tx_clock_polarity ? lo_len : hi_len;
	assign lead_len   = early ? period_len : idle_len;
	assign trail_len  = early ? idle_len : period_len;

	// Select pins XORed with their polarity bits into internal active-high enables
	assign tx_sel_act = tx_frame_sync_in ^ tx_sync_polarity;
	assign rx_sel_act = rx_frame_sync_in ^ rx_sync_polarity;

	// Slave clock edges relative to the idle level
	assign slv_lead  = (s_r.clk_prev == tx_clock_polarity) && (tx_bit_clock_in != tx_clock_polarity);
	assign slv_trail = (s_r.clk_prev != tx_clock_polarity) && (tx_bit_clock_in == tx_clock_polarity);

	assign phase_end = src_tick && (s_r.cnt == LEN_W'(1));
	// Last capture happens on the trail edge in 10b, on the lead edge in 11b
	assign last_bit  = early ? (s_r.cap_cnt == CW'(WORD_BITS)) : (s_r.cap_cnt == CW'(WORD_BITS - 1));

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt          = s_r;
		do_launch      = 1'b0;
		do_capture     = 1'b0;
		s_nxt.rx_pulse = 1'b0;
		s_nxt.master   = role_master;
		s_nxt.clk_prev = tx_bit_clock_in;

		unique case (s_r.st)
			scs_pkg::scs_st_idle: begin
				s_nxt.clk_lvl = tx_clock_polarity;
				s_nxt.sel     = 1'b0;
				s_nxt.doe     = 1'b0;
				s_nxt.away    = 1'b0;
				s_nxt.cap_cnt = '0;
				if (stop_en && role_master && tx_valid) begin
					s_nxt.txsh = tx_data;
					s_nxt.sel  = 1'b1;
					s_nxt.doe  = 1'b1;
					s_nxt.cnt  = lead_len;
					s_nxt.st   = scs_pkg::scs_st_lead;
					if (early) begin
						do_launch = 1'b1;
					end else begin
						s_nxt.dout = tx_data[WORD_BITS-1];
					end
				end else if (stop_en && !role_master && tx_sel_act) begin
					// Slave takes whatever word waits; zeros when none
					s_nxt.txsh = tx_valid ? tx_data : '0;
					s_nxt.doe  = 1'b1;
					s_nxt.st   = scs_pkg::scs_st_shift;
					if (early) begin
						do_launch = 1'b1;
					end else begin
						s_nxt.dout = s_nxt.txsh[WORD_BITS-1];
					end
				end
			end
			scs_pkg::scs_st_lead: begin
				if (phase_end) begin
					// First edge leaves the idle level
					s_nxt.clk_lvl = ~tx_clock_polarity;
					s_nxt.away    = 1'b1;
					s_nxt.cnt     = away_len;
					s_nxt.st      = scs_pkg::scs_st_shift;
					if (early) begin
						do_capture = 1'b1;
					end else begin
						do_launch  = 1'b1;
					end
				end else if (src_tick) begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			scs_pkg::scs_st_shift: begin
				if (!s_r.master) begin
					if (!tx_sel_act) begin
						s_nxt.doe = 1'b0;
						s_nxt.st  = scs_pkg::scs_st_idle;
						if (s_r.cap_cnt == CW'(WORD_BITS)) begin
							s_nxt.rx_pulse = 1'b1;
							s_nxt.rx_word  = s_r.rxsh;
						end
					end else begin
						// Captures beyond one word are dropped
						if (slv_lead) begin
							if (early) begin
								do_capture = rx_sel_act && (s_r.cap_cnt < CW'(WORD_BITS));
							end else begin
								do_launch  = 1'b1;
							end
						end
						if (slv_trail) begin
							if (early) begin
								do_launch  = 1'b1;
							end else begin
								do_capture = rx_sel_act && (s_r.cap_cnt < CW'(WORD_BITS));
							end
						end
					end
				end else if (phase_end) begin
					if (s_r.away) begin
						s_nxt.clk_lvl = tx_clock_polarity;
						s_nxt.away    = 1'b0;
						if (!early) begin
							do_capture = 1'b1;
						end else if (!last_bit) begin
							do_launch  = 1'b1;
						end
						if (last_bit) begin
							s_nxt.cnt = trail_len;
							s_nxt.st  = scs_pkg::scs_st_trail;
						end else begin
							s_nxt.cnt = idle_len;
						end
					end else begin
						s_nxt.clk_lvl = ~tx_clock_polarity;
						s_nxt.away    = 1'b1;
						s_nxt.cnt     = away_len;
						if (early) begin
							do_capture = 1'b1;
						end else begin
							do_launch  = 1'b1;
						end
					end
				end else if (src_tick) begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			scs_pkg::scs_st_trail: begin
				if (phase_end) begin
					s_nxt.sel      = 1'b0;
					s_nxt.doe      = 1'b0;
					s_nxt.rx_pulse = 1'b1;
					s_nxt.rx_word  = s_r.rxsh;
					s_nxt.st       = scs_pkg::scs_st_idle;
				end else if (src_tick) begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
		endcase

		// Shift out MSB first; shift in at the LSB
		if (do_launch) begin
			s_nxt.dout = s_nxt.txsh[WORD_BITS-1];
			s_nxt.txsh = {s_nxt.txsh[WORD_BITS-2:0], 1'b0};
		end
		if (do_capture) begin
			s_nxt.rxsh    = {s_r.rxsh[WORD_BITS-2:0], serial_data_in};
			s_nxt.cap_cnt = s_r.cap_cnt + 1'b1;
		end

		// Internal select is active high; the pin follows the polarity setting
		s_nxt.fs_pin = s_nxt.sel ^ tx_sync_polarity;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_r          <= '0;
			s_r.st       <= scs_pkg::scs_st_idle;
			s_r.fs_pin   <= `SCS_RST_LEVEL;
			s_r.clk_lvl  <= `SCS_RST_LEVEL;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins and user side
	assign tx_clock_direction = s_r.master;
	assign tx_sync_direction  = s_r.master;
	assign rx_clock_direction = 1'b0;
	assign rx_sync_direction  = 1'b0;

	assign tx_bit_clock_out  = s_r.clk_lvl;
	assign tx_bit_clock_oe   = s_r.master;
	assign tx_frame_sync_out = s_r.fs_pin;
	assign tx_frame_sync_oe  = s_r.master;

	assign serial_data_out = s_r.dout;
	assign serial_data_oe  = s_r.doe;

	assign tx_ready = (s_r.st == scs_pkg::scs_st_idle) && stop_en;
	assign rx_data  = s_r.rx_word;
	assign rx_valid = s_r.rx_pulse;
	assign busy     = (s_r.st != scs_pkg::scs_st_idle);

endmodule

// >>> verilog/scs_spi_map.svh
// Constants of the clock-stop serial port: prescale, mode codes, bit positions.
// Assumes inclusion by bare name from the design modules.
`ifndef SCS_SPI_MAP_SVH
`define SCS_SPI_MAP_SVH

// CPU clock divided by four: prescaler runs 0..3
`define SCS_PRESCALE_LAST 2'h3
`define SCS_PRESCALE_STEP 2'h1

// Clock-stop mode codes
`define SCS_MODE_STOP_LATE  2'h2
`define SCS_MODE_STOP_EARLY 2'h3
`define SCS_STOP_EN_BIT     1

// Phase length used when the divide value is zero (half a period cannot exist)
`define SCS_ZERO_DIV_PHASE 1

// Reset levels
`define SCS_RST_LEVEL 1'h0

`endif

// >>> verilog/scs_pkg.sv
// Types shared by the clock-stop serial port modules.
// Assumes the constant header is on the include path.
package scs_pkg;

	typedef enum logic [3:0] {
		scs_st_idle  = 4'h1,
		scs_st_lead  = 4'h2,
		scs_st_shift = 4'h4,
		scs_st_trail = 4'h8
	} scs_state_t;

endpackage

// >>> verilog/scs_rate_if.sv
// Carrier between the port core and its rate generator.
// Assumes both ends sit in the clk_sys domain.
`timescale 1ns/1ps

interface scs_rate_if #(
	parameter int DIV_W = 8
);
	logic [DIV_W-1:0] divide;
	logic             src_sel;
	logic             ext_clk;
	logic             src_tick;
	logic [DIV_W:0]   hi_len;
	logic [DIV_W:0]   lo_len;

	modport gen  (input divide, input src_sel, input ext_clk, output src_tick, output hi_len, output lo_len);
	modport user (output divide, output src_sel, output ext_clk, input src_tick, input hi_len, input lo_len);
endinterface

// >>> verilog/scs_rate_gen.sv
// Rate generator: source tick and bit clock phase lengths in source periods.
// Assumes the external rate clock is synchronous to clk_sys and slower than clk_sys/2.
`timescale 1ns/1ps
`include "scs_spi_map.svh"

module scs_rate_gen (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Rate settings and results
	scs_rate_if.gen  rate
);

	typedef struct packed {
		logic [1:0] pre;
		logic       ext_prev;
	} scs_rg_state_t;

	scs_rg_state_t s_r;
	scs_rg_state_t s_nxt;
	localparam int DIV_W = $bits(rate.divide);
	logic [DIV_W:0] div_ext;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt          = s_r;
		s_nxt.pre      = s_r.pre + `SCS_PRESCALE_STEP;
		s_nxt.ext_prev = rate.ext_clk;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Source is CPU/4 or rising edges of the external rate clock
	assign rate.src_tick = rate.src_sel ? (s_r.pre == `SCS_PRESCALE_LAST)
	                                    : (rate.ext_clk & ~s_r.ext_prev);

	////////////////////////////////////////////////////////////////////////
	// Phases sum to divide+1 source periods; zero divide cannot split a period
	assign div_ext = {1'b0, rate.divide};

	always_comb begin
		if (rate.divide == '0) begin
			rate.hi_len = (DIV_W+1)'(`SCS_ZERO_DIV_PHASE);
			rate.lo_len = (DIV_W+1)'(`SCS_ZERO_DIV_PHASE);
		end else if (rate.divide[0]) begin
			rate.hi_len = (div_ext + 1'b1) >> 1;
			rate.lo_len = (div_ext + 1'b1) >> 1;
		end else begin
			rate.hi_len = (div_ext >> 1) + 1'b1;
			rate.lo_len = div_ext >> 1;
		end
	end

endmodule

// >>> sim/scs_spi_checker.sv
// Pin checker for the clock-stop serial port.
// Assumes a bind onto scs_spi_port, one clock domain.
`timescale 1ns/1ps
module scs_spi_checker (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       nrst,
	// Configuration
	input wire logic       role_master,
	input wire logic [1:0] clock_stop_mode,
	input wire logic       tx_clock_polarity,
	input wire logic       tx_sync_polarity,
	// Pins and status
	input wire logic       tx_clock_direction,
	input wire logic       tx_sync_direction,
	input wire logic       tx_bit_clock_out,
	input wire logic       tx_bit_clock_oe,
	input wire logic       tx_frame_sync_in,
	input wire logic       tx_frame_sync_out,
	input wire logic       tx_frame_sync_oe,
	input wire logic       serial_data_oe,
	input wire logic       rx_valid,
	input wire logic       busy
);
	wire logic slv_sel = tx_frame_sync_in ^ tx_sync_polarity;
	wire logic fs_act  = tx_frame_sync_out != tx_sync_polarity;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	////////////////////
	dir_follow_a: assert property ($past(nrst) |-> tx_clock_direction == $past(role_master))
		else $error("direction does not follow role");
	pin_enable_a: assert property ($past(nrst) |-> tx_bit_clock_oe == $past(role_master) &&
		tx_frame_sync_oe == $past(role_master) && tx_sync_direction == $past(role_master))
		else $error("pin enable differs from role");
	idle_level_a: assert property (
		$past(nrst) && $past(tx_bit_clock_oe) && tx_bit_clock_oe && !busy && !$past(busy)
		|-> tx_bit_clock_out == tx_clock_polarity && !fs_act) else $error("idle levels wrong");
	sel_first_a: assert property (tx_bit_clock_oe && $rose(busy) |-> fs_act)
		else $error("select not active at start");
	edge_framed_a: assert property (
		tx_bit_clock_oe && $past(tx_bit_clock_oe) && $changed(tx_bit_clock_out) |-> fs_act && busy)
		else $error("clock edge outside frame");
	end_release_a: assert property (rx_valid |-> !serial_data_oe)
		else $error("data still driven at word end");
	slave_take_a: assert property (
		!tx_bit_clock_oe && !$past(tx_bit_clock_oe) && clock_stop_mode[1] && !busy && slv_sel && !$past(slv_sel)
		|-> ##[1:3] serial_data_oe) else $error("slave ignored select");
	slave_drop_a: assert property ((!tx_bit_clock_oe && !slv_sel) [*3] |-> !serial_data_oe)
		else $error("slave drives without select");
endmodule

bind scs_spi_port scs_spi_checker chk (
	.clk_sys(clk_sys), .nrst(nrst), .role_master(role_master), .clock_stop_mode(clock_stop_mode),
	.tx_clock_polarity(tx_clock_polarity), .tx_sync_polarity(tx_sync_polarity),
	.tx_clock_direction(tx_clock_direction), .tx_sync_direction(tx_sync_direction),
	.tx_bit_clock_out(tx_bit_clock_out), .tx_bit_clock_oe(tx_bit_clock_oe), .tx_frame_sync_in(tx_frame_sync_in),
	.tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe(tx_frame_sync_oe),
	.serial_data_oe(serial_data_oe), .rx_valid(rx_valid), .busy(busy)
);

// >>> sim/scs_spi_partner.sv
// Far-side slave model for the port in master role.
// Assumes the bit clock runs well below clk_sys/2.
`timescale 1ns/1ps
module scs_spi_partner (
	// Clock
	input  wire logic       clk_sys,
	// Mode and clock idle level
	input  wire logic       early,
	input  wire logic       idle_lvl,
	// Bus pins
	input  wire logic       sclk,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	output logic            miso,
	// Words
	input  wire logic [7:0] reply,
	output logic [7:0]      got
);
	logic       sclk_q;
	logic       sel_q;
	logic [7:0] sh;
	wire logic  moved = sclk != sclk_q;
	wire logic  lead  = moved && sclk_q == idle_lvl;
	wire logic  trail = moved && sclk == idle_lvl;

	initial miso = 1'b0;
	always @(posedge clk_sys) begin
		sclk_q <= sclk;
		sel_q  <= sel_n;
		if (sel_n)
			miso <= ~miso; // Released line never holds its last bit
		else if (sel_q) begin
			sh   <= early ? {reply[6:0], 1'b0} : reply;
			miso <= reply[7];
		end else begin
			if (early ? lead : trail)
				got <= {got[6:0], mosi};
			if (early ? trail : lead) begin
				miso <= sh[7];
				sh   <= sh << 1;
			end
		end
	end
endmodule

// >>> sim/scs_spi_port_test.sv
// Testbench: master words against the far-side model, slave words driven here.
// Assumes clk_sys at 50 MHz; master words run with clock and select idling high.
`timescale 1ns/1ps
module scs_spi_port_test;
	logic       clk_sys, nrst, role_master, rate_source_select, rate_clock_in, miso, m_clk, m_sel, m_dout;
	logic       tx_clock_polarity, tx_sync_polarity, rx_sync_polarity, rx_frame_sync_in;
	logic [1:0] clock_stop_mode;
	logic [7:0] clock_divide_value, tx_data, rx_data, reply, pgot;
	logic       tx_valid, tx_ready, rx_valid, busy, serial_data_out, serial_data_oe;
	logic       tx_clock_direction, rx_clock_direction, tx_sync_direction, rx_sync_direction;
	logic       tx_bit_clock_out, tx_bit_clock_oe, tx_frame_sync_out, tx_frame_sync_oe;
	wire logic  tx_bit_clock_in  = tx_bit_clock_oe ? tx_bit_clock_out : m_clk;
	wire logic  tx_frame_sync_in = tx_frame_sync_oe ? tx_frame_sync_out : m_sel;
	wire logic  serial_data_in   = role_master ? miso : m_dout;
	int         fail_count, check_count, hi_len, lo_len, tr_len, ld_len;
	time        t_ck, t_fs;
	int         dv_t [6] = '{1, 0, 2, 3, 1, 2};

	scs_spi_port #(.WORD_BITS(8), .DIV_W(8)) DUT (.clk_sys(clk_sys), .nrst(nrst), .role_master(role_master),
		.clock_stop_mode(clock_stop_mode), .tx_clock_polarity(tx_clock_polarity),
		.tx_sync_polarity(tx_sync_polarity), .rx_sync_polarity(rx_sync_polarity),
		.rate_source_select(rate_source_select), .clock_divide_value(clock_divide_value),
		.tx_clock_direction(tx_clock_direction), .rx_clock_direction(rx_clock_direction),
		.tx_sync_direction(tx_sync_direction), .rx_sync_direction(rx_sync_direction), .rate_clock_in(rate_clock_in),
		.tx_bit_clock_in(tx_bit_clock_in), .tx_bit_clock_out(tx_bit_clock_out), .tx_bit_clock_oe(tx_bit_clock_oe),
		.tx_frame_sync_in(tx_frame_sync_in), .tx_frame_sync_out(tx_frame_sync_out),
		.tx_frame_sync_oe(tx_frame_sync_oe), .rx_frame_sync_in(rx_frame_sync_in), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
	scs_spi_partner far (.clk_sys(clk_sys), .early(clock_stop_mode[0]), .idle_lvl(tx_clock_polarity),
		.sclk(tx_bit_clock_out), .sel_n(tx_frame_sync_oe ? tx_frame_sync_out : 1'b1), .mosi(serial_data_out),
		.miso(miso), .reply(reply), .got(pgot));

	////////////////////
	// Phase lengths in cycles, judged only after master words
	always @(negedge tx_bit_clock_out) begin
		hi_len = int'(($time - t_ck) / 20);
		if (t_fs > t_ck)
			ld_len = int'(($time - t_fs) / 20);
		t_ck = $time;
	end
	always @(posedge tx_bit_clock_out) begin
		lo_len = int'(($time - t_ck) / 20);
		t_ck = $time;
	end
	always @(posedge tx_frame_sync_out) tr_len = int'(($time - t_ck) / 20);
	always @(negedge tx_frame_sync_out) t_fs = $time;

	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	// External rate clock: six system cycles a period
	initial begin
		rate_clock_in = 0;
		forever begin
			repeat (3) @(negedge clk_sys);
			rate_clock_in = ~rate_clock_in;
		end
	end

	////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD %0t seen %0h want %0h", $time, seen, want);
		end
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic refuse();
		clock_stop_mode = 2'h0;
		tx_valid = 1;
		repeat (40) @(negedge clk_sys);
		check({busy, tx_ready, tx_bit_clock_out, tx_frame_sync_out}, 4'h3);
		tx_valid = 0;
	endtask

	// Two back-to-back words per setting
	task automatic master_word(input logic early, input logic src, input int d, input logic [7:0] w);
		int s, h, l, n, ld;
		s = src ? 4 : 6;
		h = d == 0 ? s : d % 2 ? (d + 1) / 2 * s : (d / 2 + 1) * s;
		l = d == 0 ? s : d % 2 ? h : d / 2 * s;
		ld = early ? h + l : h;
		clock_stop_mode = {1'b1, early};
		rate_source_select = src;
		clock_divide_value = d[7:0];
		repeat (4) @(negedge clk_sys);
		for (int k = 0; k < 2; k++) begin
			tx_data = w + 8'(k * 77);
			reply = ~w - 8'(k * 29);
			check(tx_ready, 1);
			tx_valid = 1;
			@(negedge clk_sys);
			tx_valid = 0;
			check({busy, tx_ready}, 2'h2);
			n = 0;
			while (rx_valid !== 1'b1 && n < 3000) begin
				@(negedge clk_sys);
				n++;
			end
			check(rx_valid, 1);
			check(rx_data, reply);
			check(pgot, tx_data);
			check(hi_len, h);
			check(lo_len, l);
			check(tr_len, early ? h : h + l);
			check(ld_len > ld - s && ld_len <= ld + s, 1);
		end
	endtask

	task automatic slave_word(input logic early, input logic pol, input logic [7:0] w, input logic [7:0] r);
		logic [7:0] got;
		int         n;
		role_master = 0;
		// Polarities and idle pin levels change together so no false select is seen
		{tx_clock_polarity, tx_sync_polarity, rx_sync_polarity} = {3{pol}};
		{m_clk, m_sel, rx_frame_sync_in} = {3{pol}};
		rate_source_select = 1;
		clock_divide_value = 8'h01;
		clock_stop_mode = {1'b1, early};
		tx_data = w;
		tx_valid = 1;
		repeat (4) @(negedge clk_sys);
		check({tx_clock_direction, tx_sync_direction, tx_bit_clock_oe}, 3'h0);
		{m_sel, rx_frame_sync_in, m_dout} = {~pol, ~pol, r[7]};
		repeat (8) @(negedge clk_sys);
		tx_valid = 0;
		check(serial_data_oe, 1);
		for (int i = 7; i >= 0; i--) begin
			m_clk = ~pol;
			if (early)
				got = {got[6:0], serial_data_out};
			else
				m_dout = r[i];
			repeat (8) @(negedge clk_sys);
			m_clk = pol;
			if (!early)
				got = {got[6:0], serial_data_out};
			else if (i > 0)
				m_dout = r[i-1];
			repeat (8) @(negedge clk_sys);
		end
		{m_sel, rx_frame_sync_in, m_dout} = {pol, pol, ~m_dout};
		n = 0;
		while (rx_valid !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		check(rx_valid, 1);
		check(rx_data, r);
		check(got, w);
		repeat (3) @(negedge clk_sys);
		check(serial_data_oe, 0);
	endtask

	////////////////////
	initial begin
		{nrst, tx_valid, tx_data, reply, clock_divide_value, fail_count, check_count} = '0;
		{role_master, tx_clock_polarity, tx_sync_polarity, rx_sync_polarity, rate_source_select} = '1;
		{m_clk, m_sel, m_dout, rx_frame_sync_in} = '1;
		clock_stop_mode = 2'h2;
		repeat (5) @(negedge clk_sys);
		nrst = 1;
		repeat (2) @(negedge clk_sys);
		check({tx_clock_direction, rx_clock_direction, tx_sync_direction, rx_sync_direction}, 4'ha);
		check({tx_bit_clock_out, tx_frame_sync_out, busy}, 3'h6);
		refuse();
		for (int i = 0; i < 6; i++)
			master_word(i[0], i < 4, dv_t[i], 8'ha5 + 8'(i * 19));
		slave_word(0, 1, 8'h69, 8'hd2);
		slave_word(1, 1, 8'h81, 8'h7e);
		slave_word(0, 0, 8'h3c, 8'hc5);
		slave_word(1, 0, 8'h5a, 8'h96);
		wrap_up();
	end

	initial begin
		repeat (30000) @(posedge clk_sys);
		fail_count++;
		wrap_up();
	end
endmodule
